//--- verilog/fan_core.sv
// Summary of operation
// - qualified sync fails after link timer
// - control bit 12 enables negotiation
// - hold 16-bit local advertised base page
// - store partner base or next page
// - page received needs ack and consistency
// - next-page-loaded flag tracks register seven
// - capture partner next page bit
// - power-on from supply or low power
// - resolve priority defaults off
// - defaulted variables revert outside setting states
// - track partner and local toggle bits
// - three-valued transmit source selector
// - transmit word from base or next page
// - ability match, three words ignoring ack
// - acknowledge match, three full words with ack
// - detect change of enable
// - consistency between ability and ack words
// - idle match after three idles
// - match indications restart on state entry
// - management reset and restart controls
// - link timer at least 10 ms
// - page received clears on expansion read
// - write sets next-page-loaded, machine clears
`timescale 1ns/100ps
module fan_core #(
	parameter logic [fan_pkg::LT_W-1:0] LINK_CYC = fan_pkg::LINK_CYC_DEF,
	parameter logic NP_ABLE = 1'b1
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [fan_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire fan_pkg::fan_rx_s rx_i,
	input wire logic sync_ok_i,
	input wire logic power_good_i,
	output fan_pkg::fan_xmit_e xmit_o,
	output logic [15:0] tx_cfg_word_o,
	output logic resolve_prio_o,
	output logic an_complete_o
);
	import fan_pkg::*;

	fan_regs_s r;
	fan_regs_s n;
	fan_state_e st_n;
	logic ab_match;
	logic ack_match;
	logic idle_match;
	logic consist;
	logic ab_zero;
	logic en_chg;
	logic sync_fail;
	logic power_on;
	logic t_done;
	logic wr_hit;
	logic rd_hit;
	logic [3:0] idx;
	logic [15:0] rd;

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [15:0] res;
		res = old;
		if (sel[0])
		begin
			res[7:0] = d[7:0];
		end
		if (sel[1])
		begin
			res[15:8] = d[15:8];
		end
		return res;
	endfunction : wmerge

	////////////////////////////////////////////////////////////////////////
	// decoded conditions from the current state
	assign ab_match = (r.ab_cnt == 2'h3);
	assign ack_match = (r.ack_cnt == 2'h3) && r.ack_ref[ACK_BIT];
	assign idle_match = (r.idle_cnt == 2'h3);
	assign consist = ((r.ab_word & MASK_NOACK) == (r.ack_ref & MASK_NOACK));
	assign ab_zero = ((r.ab_ref & MASK_NOACK) == 16'h0000);
	assign en_chg = (r.an_en != r.en_prev);
	assign sync_fail = (r.sync_cnt >= LINK_CYC);
	assign power_on = !power_good_i || r.low_pwr;
	assign t_done = (r.timer >= LINK_CYC);
	assign idx = wb_adr_i[5:2];
	// write and clear-on-read act at the edge where the master sees ack
	assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && r.ack;
	assign rd_hit = wb_cyc_i && wb_stb_i && !wb_we_i && r.ack;

	// read mux; reserved bits and unmapped words read zero
	always_comb
	begin
		rd = 16'h0000;
		case (idx)
			REG_CTRL:
			begin
				rd[CTRL_RESET] = r.main_rst;
				rd[CTRL_AN_EN] = r.an_en;
				rd[CTRL_LOW_PWR] = r.low_pwr;
				rd[CTRL_RESTART] = r.restart;
			end
			REG_STAT:
			begin
				rd[STAT_COMPLETE] = r.complete;
				rd[STAT_AN_ABLE] = 1'b1;
				rd[STAT_LINK] = (r.xmit == XMIT_DATA);
			end
			REG_ADV: rd = r.adv;
			REG_LP_BASE: rd = r.lp_adv;
			REG_EXP:
			begin
				rd[EXP_NP_ABLE] = NP_ABLE;
				rd[EXP_PAGE_RX] = r.page_rx;
			end
			REG_NP_TX: rd = r.np_tx;
			REG_LP_NP: rd = r.lp_np;
			default: rd = 16'h0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next-state logic for the whole core
	always_comb
	begin
		n = r;
		st_n = r.st;
		// bus slave: one wait state, ack drops in the cycle after it
		n.ack = wb_cyc_i && wb_stb_i && !r.ack;
		if (wb_cyc_i && wb_stb_i && !r.ack)
		begin
			n.dat = {16'h0000, rd};
		end
		// reset and restart act for one cycle then clear themselves
		n.main_rst = 1'b0;
		n.restart = 1'b0;
		n.en_prev = r.an_en;
		// sync qualification, saturating once the timer has elapsed
		if (sync_ok_i)
		begin
			n.sync_cnt = '0;
		end
		else if (!sync_fail)
		begin
			n.sync_cnt = r.sync_cnt + 1'b1;
		end
		if (!t_done)
		begin
			n.timer = r.timer + 1'b1;
		end
		// clear-on-read placed before the machine so a new page wins
		if (rd_hit && idx == REG_EXP)
		begin
			n.page_rx = 1'b0;
		end

		// match counters advance once per ordered set
		if (rx_i.idle)
		begin
			n.ab_cnt = 2'h0;
			n.ack_cnt = 2'h0;
			n.idle_cnt = idle_match ? 2'h3 : r.idle_cnt + 2'h1;
		end
		else if (rx_i.cfg_valid)
		begin
			n.idle_cnt = 2'h0;
			if (r.ab_cnt != 2'h0 && (rx_i.word & MASK_NOACK) == (r.ab_ref & MASK_NOACK))
			begin
				n.ab_cnt = ab_match ? 2'h3 : r.ab_cnt + 2'h1;
			end
			else
			begin
				n.ab_cnt = 2'h1;
				n.ab_ref = rx_i.word;
			end
			if (r.ack_cnt != 2'h0 && rx_i.word == r.ack_ref)
			begin
				n.ack_cnt = (r.ack_cnt == 2'h3) ? 2'h3 : r.ack_cnt + 2'h1;
			end
			else
			begin
				n.ack_cnt = 2'h1;
				n.ack_ref = rx_i.word;
			end
		end

		// negotiation sequence
		if (power_on || r.main_rst || r.restart || en_chg || sync_fail)
		begin
			st_n = ST_EN;
		end
		else
		begin
			case (r.st)
				ST_EN: st_n = r.an_en ? ST_RESTART : ST_DIS;
				ST_RESTART:
				begin
					if (t_done)
					begin
						st_n = ST_ABIL;
					end
				end
				ST_ABIL:
				begin
					if (ab_match && !ab_zero)
					begin
						st_n = ST_ACK;
					end
				end
				ST_ACK:
				begin
					if (ack_match && consist)
					begin
						st_n = ST_CACK;
					end
					else if ((ack_match && !consist) || (ab_match && ab_zero))
					begin
						st_n = ST_EN;
					end
				end
				ST_CACK:
				begin
					if (ab_match && ab_zero)
					begin
						st_n = ST_EN;
					end
					else if (t_done && ab_match)
					begin
						// continue with next pages only while either side has more
						if (r.adv[NP_BIT] && r.lp_adv[NP_BIT] && (r.np_rx || r.np_tx[NP_BIT]))
						begin
							if (r.np_loaded)
							begin
								st_n = ST_NPW;
							end
						end
						else
						begin
							st_n = ST_IDET;
						end
					end
				end
				ST_IDET:
				begin
					if (ab_match && ab_zero)
					begin
						st_n = ST_EN;
					end
					else if (t_done && idle_match)
					begin
						st_n = ST_LINK;
					end
				end
				ST_LINK:
				begin
					if (ab_match)
					begin
						st_n = ST_EN;
					end
				end
				ST_NPW:
				begin
					if (ab_match && ab_zero)
					begin
						st_n = ST_EN;
					end
					else if (ab_match && (r.tog_rx != r.ab_ref[TOG_BIT]))
					begin
						st_n = ST_ACK;
					end
				end
				ST_DIS: st_n = ST_DIS;
				default: st_n = ST_EN;
			endcase
		end
		n.st = st_n;

		// entry actions; match detection starts afresh in every state
		if (st_n != r.st)
		begin
			n.ab_cnt = 2'h0;
			n.ack_cnt = 2'h0;
			n.idle_cnt = 2'h0;
			case (st_n)
				ST_EN:
				begin
					n.page_rx = 1'b0;
					n.np_phase = 1'b0;
				end
				ST_RESTART:
				begin
					n.timer = '0;
					n.np_loaded = 1'b0;
				end
				ST_ABIL: n.tog_tx = r.adv[TOG_BIT];
				ST_ACK: n.ab_word = r.ab_ref;
				ST_CACK:
				begin
					n.timer = '0;
					n.np_rx = r.ack_ref[NP_BIT];
					n.tog_rx = r.ack_ref[TOG_BIT];
					n.tog_tx = !r.tog_tx;
					n.page_rx = 1'b1;
					if (r.np_phase)
					begin
						n.lp_np = r.ack_ref;
					end
					else
					begin
						n.lp_adv = r.ack_ref;
					end
				end
				ST_IDET: n.timer = '0;
				ST_NPW:
				begin
					n.np_loaded = 1'b0;
					n.np_phase = 1'b1;
				end
				default: n.timer = r.timer;
			endcase
		end

		// per-state outputs; defaulted ones fall back outside their states
		n.rprio = (st_n == ST_IDET) || (st_n == ST_LINK);
		n.complete = (st_n == ST_LINK);
		case (st_n)
			ST_EN: n.xmit = r.an_en ? XMIT_CONFIG : XMIT_IDLE;
			ST_IDET: n.xmit = XMIT_IDLE;
			ST_LINK, ST_DIS: n.xmit = XMIT_DATA;
			default: n.xmit = XMIT_CONFIG;
		endcase
		case (st_n)
			ST_EN, ST_RESTART: n.txw = 16'h0000;
			ST_ABIL: n.txw = r.adv & MASK_NOACK;
			ST_ACK: n.txw = r.txw | (16'h0001 << ACK_BIT);
			ST_NPW: n.txw = {r.np_tx[15], 1'b0, r.np_tx[13:12], n.tog_tx, r.np_tx[10:0]};
			default: n.txw = r.txw;
		endcase

		// register writes last so a loaded page is never lost
		if (wr_hit)
		begin
			case (idx)
				REG_CTRL:
				begin
					if (wb_sel_i[1])
					begin
						n.main_rst = wb_dat_i[CTRL_RESET];
						n.an_en = wb_dat_i[CTRL_AN_EN];
						n.low_pwr = wb_dat_i[CTRL_LOW_PWR];
						n.restart = wb_dat_i[CTRL_RESTART];
					end
				end
				REG_ADV: n.adv = wmerge(r.adv, wb_dat_i, wb_sel_i) & ADV_WR_MASK;
				REG_NP_TX:
				begin
					n.np_tx = wmerge(r.np_tx, wb_dat_i, wb_sel_i);
					n.np_loaded = 1'b1;
				end
				default: n.np_tx = n.np_tx;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register, frozen while the clock enable is low
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			r <= '0;
			r.st <= ST_EN;
			r.xmit <= XMIT_IDLE;
			r.adv <= ADV_RST;
			r.an_en <= AN_EN_RST;
			r.en_prev <= AN_EN_RST;
		end
		else if (ce_i)
		begin
			r <= n;
		end
	end

	// outputs straight from the state register
	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign xmit_o = r.xmit;
	assign tx_cfg_word_o = r.txw;
	assign resolve_prio_o = r.rprio;
	assign an_complete_o = r.complete;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	property p_sync_ok;
		ce_i && sync_ok_i |=> r.sync_cnt == '0 && !sync_fail;
	endproperty
	a_sync_ok: assert property (p_sync_ok) else $error("sync ok did not clear fail count");

	property p_en_write;
		ce_i && wr_hit && idx == REG_CTRL && wb_sel_i[1] |=> r.an_en == $past(wb_dat_i[CTRL_AN_EN]);
	endproperty
	a_en_write: assert property (p_en_write) else $error("enable bit not taken");

	property p_page_rx;
		ce_i && !r.page_rx && n.page_rx |-> ack_match && consist && r.st == ST_ACK;
	endproperty
	a_page_rx: assert property (p_page_rx) else $error("page received without matches");

	property p_np_loaded;
		ce_i && wr_hit && idx == REG_NP_TX |=> r.np_loaded;
	endproperty
	a_np_loaded: assert property (p_np_loaded) else $error("next page loaded not set");

	property p_ab_idle;
		ce_i && rx_i.idle |=> r.ab_cnt == 2'h0 && r.ack_cnt == 2'h0;
	endproperty
	a_ab_idle: assert property (p_ab_idle) else $error("idle did not reset matches");

	property p_idle_cfg;
		ce_i && rx_i.cfg_valid && !rx_i.idle |=> r.idle_cnt == 2'h0;
	endproperty
	a_idle_cfg: assert property (p_idle_cfg) else $error("config did not reset idle count");

	property p_entry;
		ce_i && st_n != r.st |=> !ab_match && r.ack_cnt == 2'h0 && !idle_match;
	endproperty
	a_entry: assert property (p_entry) else $error("match survived state entry");

	property p_link_data;
		r.st == ST_LINK && ce_i && st_n == ST_LINK |=> xmit_o == XMIT_DATA && an_complete_o;
	endproperty
	a_link_data: assert property (p_link_data) else $error("link ok without data source");

	property p_rprio;
		resolve_prio_o |-> r.st == ST_IDET || r.st == ST_LINK;
	endproperty
	a_rprio: assert property (p_rprio) else $error("priority resolution outside its states");

	property p_read_clear;
		ce_i && rd_hit && idx == REG_EXP && st_n == r.st |=> !r.page_rx;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("page received not cleared");

	property p_ack_pulse;
		wb_ack_o && ce_i |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");

	c_link: cover property (r.st == ST_IDET ##1 r.st == ST_LINK);
	c_page: cover property (!r.page_rx ##1 r.page_rx);
	c_npw: cover property (r.st == ST_NPW);
	c_sync_fail: cover property (sync_fail);

endmodule : fan_core

//--- include/fan_pkg.sv
// shared constants and carriers of the fibre link negotiation core
package fan_pkg;

	////////////////////////////////////////////////////////////////////////
	// timing: link timer of 10 ms at a 10 ns clock
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned LINK_TIMER_MS = 10;
	localparam int unsigned LINK_TIMER_CYC = LINK_TIMER_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned LT_W = 21;
	localparam logic [LT_W-1:0] LINK_CYC_DEF = LT_W'(LINK_TIMER_CYC);

	////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam int unsigned ADR_W = 6;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h1;
	localparam logic [3:0] REG_ADV = 4'h4;
	localparam logic [3:0] REG_LP_BASE = 4'h5;
	localparam logic [3:0] REG_EXP = 4'h6;
	localparam logic [3:0] REG_NP_TX = 4'h7;
	localparam logic [3:0] REG_LP_NP = 4'h8;

	// control and status bit positions
	localparam int unsigned CTRL_RESET = 15;
	localparam int unsigned CTRL_AN_EN = 12;
	localparam int unsigned CTRL_LOW_PWR = 11;
	localparam int unsigned CTRL_RESTART = 9;
	localparam int unsigned STAT_COMPLETE = 5;
	localparam int unsigned STAT_AN_ABLE = 3;
	localparam int unsigned STAT_LINK = 2;
	localparam int unsigned EXP_NP_ABLE = 2;
	localparam int unsigned EXP_PAGE_RX = 1;

	// configuration word layout
	localparam int unsigned NP_BIT = 15;
	localparam int unsigned ACK_BIT = 14;
	localparam int unsigned TOG_BIT = 11;
	localparam logic [15:0] MASK_NOACK = 16'hbfff;
	localparam logic [15:0] ADV_WR_MASK = 16'hb1e0;

	// reset values
	localparam logic [15:0] ADV_RST = 16'h0020;
	localparam logic AN_EN_RST = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// enumerations
	typedef enum logic [1:0] {XMIT_IDLE, XMIT_CONFIG, XMIT_DATA} fan_xmit_e;
	typedef enum logic [3:0] {ST_EN, ST_RESTART, ST_ABIL, ST_ACK, ST_CACK,
		ST_IDET, ST_LINK, ST_NPW, ST_DIS} fan_state_e;

	// receive carrier: one strobe per ordered set
	typedef struct packed {
		logic cfg_valid;
		logic idle;
		logic [15:0] word;
	} fan_rx_s;

	// complete state of the core
	typedef struct packed {
		fan_state_e st;
		fan_xmit_e xmit;
		logic [15:0] adv;
		logic [15:0] lp_adv;
		logic [15:0] lp_np;
		logic [15:0] np_tx;
		logic [15:0] txw;
		logic [15:0] ab_ref;
		logic [15:0] ack_ref;
		logic [15:0] ab_word;
		logic [1:0] ab_cnt;
		logic [1:0] ack_cnt;
		logic [1:0] idle_cnt;
		logic [LT_W-1:0] timer;
		logic [LT_W-1:0] sync_cnt;
		logic an_en;
		logic en_prev;
		logic low_pwr;
		logic main_rst;
		logic restart;
		logic np_loaded;
		logic page_rx;
		logic np_phase;
		logic np_rx;
		logic tog_rx;
		logic tog_tx;
		logic complete;
		logic rprio;
		logic ack;
		logic [31:0] dat;
	} fan_regs_s;

endpackage : fan_pkg

//--- tb/fan_lp_model.sv
`timescale 1ns/100ps
module fan_lp_model
	import fan_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic slow_i,
	input wire logic [15:0] base_i,
	input wire fan_pkg::fan_xmit_e xmit_i,
	input wire logic [15:0] tx_word_i,
	output fan_pkg::fan_rx_s rx_o
);
	logic ph_r;

	////////////////////////////////////////////////////////////////////////
	// one ordered set a cycle, or every other cycle when slow
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			ph_r <= 1'b0;
			rx_o <= '0;
		end
		else
		begin
			ph_r <= ~ph_r;
			rx_o.word <= ~rx_o.word; // no stale word between sets
			rx_o.cfg_valid <= 1'b0;
			rx_o.idle <= 1'b0;
			if (!slow_i || ph_r)
			begin
				// acknowledge once the local side shows a nonzero page
				if (xmit_i == XMIT_CONFIG)
				begin
					rx_o.cfg_valid <= 1'b1;
					rx_o.word <= base_i | (16'(|tx_word_i) << ACK_BIT);
				end
				else
				begin
					rx_o.idle <= 1'b1;
				end
			end
		end
	end
endmodule : fan_lp_model

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
	import fan_pkg::*;
	localparam int LC = 20;
	logic clk_i, sys_rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o;
	logic sync_ok, pgood, slow, rprio, cplt, ce;
	logic [5:0] wb_adr;
	logic [31:0] wb_dat, wb_dat_o, rd;
	logic [15:0] tx_w, base, adv, nw;
	logic [15:0] seed = 16'h98c3;
	fan_rx_s rx;
	fan_xmit_e xmit_o;
	int failures = 0;
	int n_compared = 0;

	////////////////////////////////////////////////////////////////////////
	fan_core #(.LINK_CYC(21'd20), .NP_ABLE(1'b1)) uut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'h3), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.rx_i(rx), .sync_ok_i(sync_ok), .power_good_i(pgood), .xmit_o(xmit_o),
		.tx_cfg_word_o(tx_w), .resolve_prio_o(rprio), .an_complete_o(cplt));

	fan_lp_model lp (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow), .base_i(base),
		.xmit_i(xmit_o), .tx_word_i(tx_w), .rx_o(rx));

	////////////////////////////////////////////////////////////////////////
	// free running clock
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction : rnd

	// status as software should see it
	function automatic logic [31:0] exp_stat(input logic done);
		return (32'(done) << STAT_COMPLETE) | (32'h1 << STAT_AN_ABLE) | (32'(done) << STAT_LINK);
	endfunction : exp_stat

	function automatic logic hit(input int k);
		case (k)
			0: return tx_w[ACK_BIT] === 1'b1;
			1: return xmit_o === XMIT_IDLE;
			2: return xmit_o === XMIT_DATA;
			default: return xmit_o === XMIT_CONFIG;
		endcase
	endfunction : hit

	task automatic print_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one classic cycle; request held until ack is sampled
	task automatic wb(input logic we, input logic [3:0] idx, input logic [15:0] wd);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'b00};
		wb_dat <= {16'h0, wd};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20)
			chk("bus ack", 1, 0);
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	// bounded wait for an output condition
	task automatic wt(input int k);
		int n;
		for (n = 0; n < 600 && !hit(k); n++)
			@(posedge clk_i);
		if (n == 600)
			chk("wait", k, 32'hffff);
	endtask : wt

	////////////////////////////////////////////////////////////////////////
	// watchdog sized well beyond six negotiations
	initial
	begin
		repeat (20000) @(posedge clk_i);
		failures++;
		print_verdict();
	end

	// main sequence: reset values, then negotiations with a disruption each
	initial
	begin
		int r;
		{wb_cyc, wb_stb, wb_we, slow} = '0;
		wb_adr = '0;
		wb_dat = '0;
		rd = '0;
		base = 16'h0020;
		{ce, sync_ok, pgood, sys_rst_i} = 4'hf;
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		wb(1'b0, REG_CTRL, 16'h0);
		chk("ctrl", 32'(AN_EN_RST) << CTRL_AN_EN, rd);
		wb(1'b0, REG_ADV, 16'h0);
		chk("adv", 32'(ADV_RST), rd);
		wb(1'b0, REG_EXP, 16'h0);
		chk("exp", 32'h1 << EXP_NP_ABLE, rd);
		wb(1'b1, 4'hf, rnd());
		wb(1'b0, 4'hf, 16'h0);
		chk("unmapped", 0, rd);
		for (r = 0; r < 6; r++)
		begin
			adv = (rnd() & ADV_WR_MASK & 16'h7fff) | ADV_RST;
			base <= (rnd() & MASK_NOACK & 16'h7fff) | 16'h0020;
			slow <= r[0];
			wb(1'b1, REG_ADV, adv);
			wb(1'b1, REG_CTRL, 16'h1200);
			repeat (3) @(posedge clk_i);
			wt(0);
			chk("tx ack page", adv | 16'h4000, tx_w);
			wt(1);
			chk("prio", 1, rprio);
			wt(2);
			chk("done", 1, cplt);
			wb(1'b0, REG_STAT, 16'h0);
			chk("stat", exp_stat(1'b1), rd);
			wb(1'b1, REG_LP_BASE, ~base);
			wb(1'b0, REG_LP_BASE, 16'h0);
			chk("lp base", 32'(base) | 32'h4000, rd);
			wb(1'b0, REG_EXP, 16'h0);
			chk("page rx", 32'h6, rd);
			wb(1'b0, REG_EXP, 16'h0);
			chk("page rx clr", 32'h4, rd);
			wb(1'b0, REG_LP_NP, 16'h0);
			chk("lp np", 0, rd);
			nw = rnd();
			wb(1'b1, REG_NP_TX, nw);
			wb(1'b0, REG_NP_TX, 16'h0);
			chk("np tx", nw, rd);
			case (r)
				0:
				begin
					sync_ok <= 1'b0;
					repeat (LC) @(posedge clk_i);
					chk("short sync loss", 1, cplt);
					repeat (15) @(posedge clk_i);
					chk("long sync loss", 0, cplt);
					sync_ok <= 1'b1;
				end
				1:
				begin
					wb(1'b1, REG_CTRL, 16'h9000);
					repeat (3) @(posedge clk_i);
					chk("main reset", 0, cplt);
					chk("prio off", 0, rprio);
				end
				2:
				begin
					wb(1'b1, REG_CTRL, 16'h0);
					repeat (6) @(posedge clk_i);
					chk("disabled xmit", XMIT_DATA, xmit_o);
					chk("disabled done", 0, cplt);
					wb(1'b1, REG_CTRL, 16'h1000);
					wt(3);
				end
				3:
				begin
					wb(1'b1, REG_CTRL, 16'h1800);
					repeat (5) @(posedge clk_i);
					chk("low power", 0, cplt);
				end
				4:
				begin
					pgood <= 1'b0;
					repeat (5) @(posedge clk_i);
					chk("no power", 0, cplt);
					pgood <= 1'b1;
				end
				default:
				begin
					// clock enable low must hold every flop, even with the supply lost
					ce <= 1'b0;
					pgood <= 1'b0;
					repeat (5) @(posedge clk_i);
					chk("frozen done", 1, cplt);
					chk("frozen xmit", XMIT_DATA, xmit_o);
					ce <= 1'b1;
					pgood <= 1'b1;
					wb(1'b1, REG_CTRL, 16'h1200);
					repeat (3) @(posedge clk_i);
					chk("restart", 0, cplt);
				end
			endcase
		end
		print_verdict();
	end
endmodule : tb
